// File: verilog/asfm_top.sv
// Sample buffer with four storage policies and host byte read-out
//
// Functional notes
// - Store holds 512 entries, each one axis or temperature value.
// - Capacity is 170 XYZ sets or 128 XYZ plus temperature sets.
// - Policy 0b00 stores nothing and empties the store.
// - Policy 0b01 fills to full, then accepts only as reads free space.
// - Policy 0b10 keeps newest data, dropping oldest entry when full.
// - Watermark raised once count reaches the target with its high bit.
// - Policy 0b11 keeps target-many entries before an activity event.
// - Separate events for data available, watermark and overrun.
// - Entries written X, Y, Z, then optional temperature.
// - Entry is 16 bits, low byte first, sign bits, type code on top.
// - Host reads even byte counts; reads past empty return zero.
// - Reading until a condition fails clears its event.
`timescale 1ns/10ps
`default_nettype none
module asfm_top (
	input  wire logic                        clk_i,      // Sample clock
	input  wire logic                        rst_i,      // Sync reset
	input  wire logic                        reg_wr_i,   // Register write
	input  wire logic                        reg_rd_i,   // Register read
	input  wire logic [7:0]                  reg_addr_i, // Register address
	input  wire logic [7:0]                  reg_wdata_i,// Write data
	output logic      [7:0]                  reg_rdata_o,// Read data
	input  wire logic                        buf_rd_i,   // Buffer byte read
	output logic      [7:0]                  buf_byte_o, // Buffer byte
	input  wire logic                        set_valid_i,// New sample set
	input  wire logic [asfm_pkg::ASFM_DW-1:0] x_i,       // X axis
	input  wire logic [asfm_pkg::ASFM_DW-1:0] y_i,       // Y axis
	input  wire logic [asfm_pkg::ASFM_DW-1:0] z_i,       // Z axis
	input  wire logic [asfm_pkg::ASFM_DW-1:0] t_i,       // Temperature
	input  wire logic                        activity_i, // Activity event
	output logic                             avail_o,    // Data available
	output logic                             watermark_o,// Target reached
	output logic                             overrun_o   // Samples lost
);
	import asfm_pkg::*;

	logic [7:0]          ctrl_r, target_r;
	logic [ASFM_EW-1:0]  mem_r [ASFM_DEPTH];
	logic [ASFM_AW-1:0]  wp_r, rp_r;
	logic [ASFM_CW-1:0]  cnt_r, cnt_nxt, lvl;
	logic [ASFM_EW-1:0]  hold_r;
	logic                phase_r, trig_r, wm_r, ovr_r;
	logic [1:0]          mode;
	logic                off, full, pop, wr, drop, loss;
	logic                seq_valid, seq_ready, seq_lost;
	logic [ASFM_EW-1:0]  seq_data, stg_data;
	logic                stg_valid, stg_ready;

	assign mode = ctrl_r[ASFM_MODE_HI:ASFM_MODE_LO];
	assign off  = mode == ASFM_MODE_OFF;
	// Nine-bit level: high control bit above the target byte
	assign lvl  = {1'b0, ctrl_r[ASFM_AH_BIT], target_r};
	assign full = cnt_r == ASFM_FULL_CNT;

	// Set sequencer; stalls on a full staging buffer
	asfm_seq u_seq (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.set_valid_i (set_valid_i),
		.x_i         (x_i),
		.y_i         (y_i),
		.z_i         (z_i),
		.t_i         (t_i),
		.temp_en_i   (ctrl_r[ASFM_TEMP_BIT]),
		.out_valid_o (seq_valid),
		.out_ready_i (seq_ready),
		.out_data_o  (seq_data),
		.lost_o      (seq_lost)
	);

	// Staging buffer absorbs bursts while the store is held back
	asfm_fifo #(
		.W (ASFM_EW),
		.D (ASFM_STG_DEPTH)
	) u_stg (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (off),
		.in_valid_i  (seq_valid),
		.in_ready_o  (seq_ready),
		.in_data_i   (seq_data),
		.out_valid_o (stg_valid),
		.out_ready_i (stg_ready),
		.out_data_o  (stg_data)
	);

	// Host takes an entry on each low-byte read
	assign pop = buf_rd_i && !phase_r && cnt_r != '0 && !off;

	// Store admission per policy
	always_comb begin
		stg_ready = 1'b1;
		wr        = 1'b0;
		drop      = 1'b0;
		case (mode)
		ASFM_MODE_OLDEST: begin
			stg_ready = !full || pop;
			wr        = stg_valid && stg_ready;
		end
		ASFM_MODE_STREAM: begin
			wr   = stg_valid;
			drop = stg_valid && full && !pop;
		end
		ASFM_MODE_TRIG: begin
			if (trig_r) begin
				// Overflow after capture is discarded, not stalled
				wr = stg_valid && (!full || pop);
			end else if (lvl != '0) begin
				wr   = stg_valid;
				drop = stg_valid && cnt_r >= lvl && !pop;
			end
		end
		default: begin
			wr = 1'b0;
		end
		endcase
	end

	assign cnt_nxt = cnt_r + ASFM_CW'(wr) - ASFM_CW'(pop | drop);
	assign loss    = (mode == ASFM_MODE_STREAM && drop) || seq_lost;

	// Control registers written by the host
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r   <= ASFM_CTRL_RST;
			target_r <= ASFM_TARGET_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ASFM_ADDR_CTRL)
				ctrl_r <= reg_wdata_i & ASFM_CTRL_MASK;
			if (reg_addr_i == ASFM_ADDR_TARGET)
				target_r <= reg_wdata_i;
		end
	end

	// Register read-back; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i)
			reg_rdata_o <= ASFM_RD_NONE;
		else if (reg_rd_i) begin
			case (reg_addr_i)
			ASFM_ADDR_CTRL:   reg_rdata_o <= ctrl_r;
			ASFM_ADDR_TARGET: reg_rdata_o <= target_r;
			default:          reg_rdata_o <= ASFM_RD_NONE;
			endcase
		end
	end

	// One-shot trigger; any policy write re-arms it
	// An event in the write cycle wins only if the policy is already 0b11
	always_ff @(posedge clk_i) begin
		if (rst_i)
			trig_r <= 1'b0;
		else if (mode == ASFM_MODE_TRIG && activity_i)
			trig_r <= 1'b1;
		else if (reg_wr_i && reg_addr_i == ASFM_ADDR_CTRL)
			trig_r <= 1'b0;
	end

	// Entry storage
	always_ff @(posedge clk_i) begin
		if (wr)
			mem_r[wp_r] <= stg_data;
	end

	// Pointers and count; disabled policy empties the store
	always_ff @(posedge clk_i) begin
		if (rst_i || off) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr)
				wp_r <= wp_r + ASFM_PTR_ONE;
			if (pop || drop)
				rp_r <= rp_r + ASFM_PTR_ONE;
			cnt_r <= cnt_nxt;
		end
	end

	// Byte read-out, low byte first, zeros once empty
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_r    <= 1'b0;
			hold_r     <= '0;
			buf_byte_o <= 8'h00;
		end else if (buf_rd_i) begin
			phase_r <= !phase_r;
			if (!phase_r) begin
				hold_r     <= pop ? mem_r[rp_r] : '0;
				buf_byte_o <= pop ? mem_r[rp_r][7:0] : 8'h00;
			end else begin
				buf_byte_o <= hold_r[15:8];
			end
		end
	end

	// Event flags follow the store level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avail_o <= 1'b0;
			wm_r    <= 1'b0;
		end else begin
			avail_o <= !off && cnt_nxt != '0;
			wm_r    <= !off && cnt_nxt != '0 && cnt_nxt >= lvl;
		end
	end
	assign watermark_o = wm_r;

	// Overrun sticks until a read frees space; a new loss wins
	always_ff @(posedge clk_i) begin
		if (rst_i || off)
			ovr_r <= 1'b0;
		else if (loss)
			ovr_r <= 1'b1;
		else if (pop)
			ovr_r <= 1'b0;
	end
	assign overrun_o = ovr_r;

	property p_off_empty;
		@(posedge clk_i) disable iff (rst_i)
		off |=> cnt_r == '0 && !avail_o;
	endproperty
	a_off_empty: assert property (p_off_empty)
		else $error("disabled policy left entries");

	property p_cap;
		@(posedge clk_i) disable iff (rst_i)
		cnt_r <= ASFM_FULL_CNT;
	endproperty
	a_cap: assert property (p_cap)
		else $error("store count above capacity");

	property p_oldest_hold;
		@(posedge clk_i) disable iff (rst_i)
		(mode == ASFM_MODE_OLDEST && full && !pop && !reg_wr_i)
			|=> $stable(wp_r) && full;
	endproperty
	a_oldest_hold: assert property (p_oldest_hold)
		else $error("oldest policy wrote into a full store");

	property p_stream_drop;
		@(posedge clk_i) disable iff (rst_i)
		(mode == ASFM_MODE_STREAM && full && stg_valid && !pop)
			|=> full && rp_r == $past(rp_r) + ASFM_PTR_ONE && ovr_r;
	endproperty
	a_stream_drop: assert property (p_stream_drop)
		else $error("stream policy failed to drop oldest");

	property p_watermark;
		@(posedge clk_i) disable iff (rst_i)
		($stable(lvl) && !off && !$past(off)) |->
			wm_r == (cnt_r != '0 && cnt_r >= lvl);
	endproperty
	a_watermark: assert property (p_watermark)
		else $error("watermark disagrees with level");

	property p_pretrig;
		@(posedge clk_i) disable iff (rst_i)
		(mode == ASFM_MODE_TRIG && !trig_r && lvl != '0 && cnt_r <= lvl)
			|=> cnt_r <= $past(lvl);
	endproperty
	a_pretrig: assert property (p_pretrig)
		else $error("pre-event history exceeds target");

	property p_trig_stop;
		@(posedge clk_i) disable iff (rst_i)
		(mode == ASFM_MODE_TRIG && trig_r && full && !pop)
			|=> $stable(wp_r);
	endproperty
	a_trig_stop: assert property (p_trig_stop)
		else $error("capture continued past full");

	property p_avail;
		@(posedge clk_i) disable iff (rst_i)
		!$past(off) |-> avail_o == (cnt_r != '0);
	endproperty
	a_avail: assert property (p_avail)
		else $error("data available flag wrong");

	property p_zero_read;
		@(posedge clk_i) disable iff (rst_i)
		(buf_rd_i && !phase_r && (cnt_r == '0 || off))
			|=> buf_byte_o == 8'h00 && hold_r == '0;
	endproperty
	a_zero_read: assert property (p_zero_read)
		else $error("read past empty returned data");

	property p_ovr_clear;
		@(posedge clk_i) disable iff (rst_i)
		(ovr_r && pop && !loss) |=> !ovr_r;
	endproperty
	a_ovr_clear: assert property (p_ovr_clear)
		else $error("overrun not cleared by read");

	property p_rearm;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == ASFM_ADDR_CTRL
			&& !(mode == ASFM_MODE_TRIG && activity_i)) |=> !trig_r;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("policy write did not re-arm capture");

	c_stream_drop: cover property (@(posedge clk_i) drop && !trig_r);
	c_trigger: cover property (@(posedge clk_i) $rose(trig_r));
	c_overrun: cover property (@(posedge clk_i) $rose(ovr_r));
	c_full: cover property (@(posedge clk_i) full && mode == ASFM_MODE_OLDEST);
	c_empty_rd: cover property (@(posedge clk_i) pop == 1'b0 && buf_rd_i && !phase_r);
endmodule
`default_nettype wire

// File: verilog/asfm_pkg.sv
// Shared constants and types for the accelerometer sample buffer
package asfm_pkg;
	// Register map
	localparam logic [7:0] ASFM_ADDR_CTRL   = 8'h28;
	localparam logic [7:0] ASFM_ADDR_TARGET = 8'h29;
	localparam logic [7:0] ASFM_CTRL_RST    = 8'h00;
	localparam logic [7:0] ASFM_TARGET_RST  = 8'h00;
	localparam logic [7:0] ASFM_CTRL_MASK   = 8'h0f;
	localparam logic [7:0] ASFM_RD_NONE     = 8'h00;
	// Control field positions
	localparam int ASFM_MODE_LO  = 0;
	localparam int ASFM_MODE_HI  = 1;
	localparam int ASFM_TEMP_BIT = 2;
	localparam int ASFM_AH_BIT   = 3;
	// Buffer policies
	localparam logic [1:0] ASFM_MODE_OFF    = 2'h0;
	localparam logic [1:0] ASFM_MODE_OLDEST = 2'h1;
	localparam logic [1:0] ASFM_MODE_STREAM = 2'h2;
	localparam logic [1:0] ASFM_MODE_TRIG   = 2'h3;
	// Entry format
	localparam int ASFM_DW = 12;
	localparam int ASFM_EW = 16;
	localparam logic [1:0] ASFM_TYPE_X = 2'h0;
	localparam logic [1:0] ASFM_TYPE_Y = 2'h1;
	localparam logic [1:0] ASFM_TYPE_Z = 2'h2;
	localparam logic [1:0] ASFM_TYPE_T = 2'h3;
	// Store geometry
	localparam int ASFM_DEPTH     = 512;
	localparam int ASFM_AW        = 9;
	localparam int ASFM_CW        = 10;
	localparam int ASFM_SETS_XYZ  = 170;
	localparam int ASFM_SETS_XYZT = 128;
	localparam logic [ASFM_CW-1:0] ASFM_FULL_CNT = 10'h200;
	localparam logic [ASFM_CW-1:0] ASFM_CNT_ONE  = 10'h001;
	localparam logic [ASFM_AW-1:0] ASFM_PTR_ONE  = 9'h001;
	// Staging buffer ahead of the store
	localparam int ASFM_STG_DEPTH = 32;
	// Set sequencer states
	typedef enum logic [4:0] {
		ASFM_SEQ_IDLE = 5'b00001,
		ASFM_SEQ_X    = 5'b00010,
		ASFM_SEQ_Y    = 5'b00100,
		ASFM_SEQ_Z    = 5'b01000,
		ASFM_SEQ_T    = 5'b10000
	} asfm_seq_t;
endpackage

// File: verilog/asfm_fifo.sv
// Generic valid/ready staging FIFO
`timescale 1ns/10ps
`default_nettype none
module asfm_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	input  wire logic         clk_i,      // Clock
	input  wire logic         rst_i,      // Sync reset, high
	input  wire logic         flush_i,    // Drop all content
	input  wire logic         in_valid_i, // Write side valid
	output logic              in_ready_o, // Write side ready
	input  wire logic [W-1:0] in_data_i,  // Write data
	output logic              out_valid_o,// Read side valid
	input  wire logic         out_ready_i,// Read side ready
	output logic [W-1:0]      out_data_o  // Read data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	logic [W-1:0]  mem_r [D];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0]   cnt_r;
	logic          push, pop;

	// Honest flags; full stalls the writer
	assign in_ready_o  = cnt_r != FULL;
	assign out_valid_o = cnt_r != '0;
	assign out_data_o  = mem_r[rp_r];
	assign push = in_valid_i & in_ready_o;
	assign pop  = out_valid_o & out_ready_i;

	// Storage array
	always_ff @(posedge clk_i) begin
		if (push)
			mem_r[wp_r] <= in_data_i;
	end

	// Pointers and occupancy
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + AW'(1);
			if (pop)
				rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + AW'(1);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	property p_no_overfill;
		@(posedge clk_i) disable iff (rst_i)
		(cnt_r <= FULL) && (cnt_r != FULL || !in_ready_o);
	endproperty
	a_no_overfill: assert property (p_no_overfill)
		else $error("staging fifo accepts while full");
endmodule
`default_nettype wire

// File: verilog/asfm_seq.sv
// Splits each acquired sample set into typed buffer entries
`timescale 1ns/10ps
`default_nettype none
module asfm_seq
	import asfm_pkg::*;
(
	input  wire logic               clk_i,      // Clock
	input  wire logic               rst_i,      // Sync reset, high
	input  wire logic               set_valid_i,// New sample set pulse
	input  wire logic [ASFM_DW-1:0] x_i,        // X axis
	input  wire logic [ASFM_DW-1:0] y_i,        // Y axis
	input  wire logic [ASFM_DW-1:0] z_i,        // Z axis
	input  wire logic [ASFM_DW-1:0] t_i,        // Temperature
	input  wire logic               temp_en_i,  // Store temperature too
	output logic                    out_valid_o,// Entry valid
	input  wire logic               out_ready_i,// Entry accepted
	output logic [ASFM_EW-1:0]      out_data_o, // Formatted entry
	output logic                    lost_o      // Set dropped, busy
);
	asfm_seq_t            st_r;
	logic [ASFM_DW-1:0]   x_r, y_r, z_r, t_r;
	logic                 ten_r;

	// Type code, two sign bits, twelve data bits
	function automatic logic [ASFM_EW-1:0] fmt(input logic [1:0] ty,
			input logic [ASFM_DW-1:0] d);
		fmt = {ty, {2{d[ASFM_DW-1]}}, d};
	endfunction

	// Capture a set only when idle; a busy sequencer loses it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= ASFM_SEQ_IDLE;
			ten_r <= 1'b0;
		end else begin
			case (st_r)
			ASFM_SEQ_IDLE: if (set_valid_i) begin
				st_r  <= ASFM_SEQ_X;
				ten_r <= temp_en_i;
			end
			ASFM_SEQ_X: if (out_ready_i) st_r <= ASFM_SEQ_Y;
			ASFM_SEQ_Y: if (out_ready_i) st_r <= ASFM_SEQ_Z;
			ASFM_SEQ_Z: if (out_ready_i)
				st_r <= ten_r ? ASFM_SEQ_T : ASFM_SEQ_IDLE;
			ASFM_SEQ_T: if (out_ready_i) st_r <= ASFM_SEQ_IDLE;
			default: st_r <= ASFM_SEQ_IDLE;
			endcase
		end
	end

	// Sample latch
	always_ff @(posedge clk_i) begin
		if (st_r == ASFM_SEQ_IDLE && set_valid_i) begin
			x_r <= x_i;
			y_r <= y_i;
			z_r <= z_i;
			t_r <= t_i;
		end
	end

	// Entry mux
	always_comb begin
		out_valid_o = 1'b1;
		case (st_r)
		ASFM_SEQ_X: out_data_o = fmt(ASFM_TYPE_X, x_r);
		ASFM_SEQ_Y: out_data_o = fmt(ASFM_TYPE_Y, y_r);
		ASFM_SEQ_Z: out_data_o = fmt(ASFM_TYPE_Z, z_r);
		ASFM_SEQ_T: out_data_o = fmt(ASFM_TYPE_T, t_r);
		default: begin
			out_valid_o = 1'b0;
			out_data_o  = '0;
		end
		endcase
	end

	assign lost_o = set_valid_i && st_r != ASFM_SEQ_IDLE;

	property p_xyz_order;
		@(posedge clk_i) disable iff (rst_i)
		(st_r == ASFM_SEQ_X && out_ready_i) |=>
			out_valid_o && out_data_o[15:14] == ASFM_TYPE_Y;
	endproperty
	a_xyz_order: assert property (p_xyz_order)
		else $error("Y entry does not follow X");
endmodule
`default_nettype wire

// File: verif/asfm_host_model.sv
// Host side model: register access and buffer byte read-out
`timescale 1ns/10ps
`default_nettype none
module asfm_host_model (
	input  wire logic       clk_i,       // Sample clock
	output logic            reg_wr_o,    // Register write strobe
	output logic            reg_rd_o,    // Register read strobe
	output logic [7:0]      reg_addr_o,  // Register address
	output logic [7:0]      reg_wdata_o, // Register write data
	input  wire logic [7:0] reg_rdata_i, // Register read data
	output logic            buf_rd_o,    // Buffer byte strobe
	input  wire logic [7:0] buf_byte_i   // Buffer byte
);
	// Idle bus from time zero
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		buf_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// Write strobe of one cycle; released lines show inverted junk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	// Read data is registered, so it is taken just after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_rd_o = 1'b1;
		reg_addr_o = a;
		@(posedge clk_i);
		#1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		d = reg_rdata_i;
	endtask

	// One byte per strobe
	task automatic rd_byte(output logic [7:0] b);
		@(posedge clk_i);
		#1;
		buf_rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		buf_rd_o = 1'b0;
		b = buf_byte_i;
	endtask

	// Always two bytes, low first, so the byte phase never slips
	task automatic rd_entry(output logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		rd_byte(lo);
		rd_byte(hi);
		e = {hi, lo};
	endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the sample buffer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import asfm_pkg::*;
	logic clk, rst, reg_wr, reg_rd, buf_rd, set_valid, activity;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, buf_byte, r8;
	logic [ASFM_DW-1:0] x, y, z, t;
	logic avail, watermark, overrun;
	logic [15:0] e, first, last;
	int fail_count = 0;
	int total_checks = 0;
	int n;

	asfm_top uut (.clk_i(clk), .rst_i(rst), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata), .buf_rd_i(buf_rd), .buf_byte_o(buf_byte),
		.set_valid_i(set_valid), .x_i(x), .y_i(y), .z_i(z), .t_i(t),
		.activity_i(activity), .avail_o(avail), .watermark_o(watermark),
		.overrun_o(overrun));
	asfm_host_model host (.clk_i(clk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
		.reg_rdata_i(reg_rdata), .buf_rd_o(buf_rd), .buf_byte_i(buf_byte));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	// Expected entry: type on top, two sign copies, twelve data bits
	function automatic logic [15:0] ent(logic [1:0] ty, logic [11:0] d);
		return {ty, d[11], d[11], d};
	endfunction

	// Sets spaced five cycles apart, above the four-cycle minimum
	task automatic send(input logic [11:0] a, b, c, d);
		@(posedge clk);
		#1;
		set_valid = 1'b1;
		{x, y, z, t} = {a, b, c, d};
		@(posedge clk);
		#1;
		set_valid = 1'b0;
		{x, y, z, t} = ~{a, b, c, d};
		repeat (3) @(posedge clk);
	endtask

	// Set i carries i on every axis
	task automatic burst(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			send(12'(i), 12'(i), 12'(i), 12'h000);
		end
	endtask

	// Enough for 32 staged entries to reach the store
	task automatic settle();
		repeat (40) @(posedge clk);
	endtask

	// Reads whole entries while data is flagged, bounded
	task automatic drain();
		n = 0;
		while (avail === 1'b1 && n < 600) begin
			host.rd_entry(e);
			if (n == 0) first = e;
			last = e;
			n++;
		end
		if (n >= 600) begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic mode(input logic [7:0] c, input logic [7:0] lvl);
		host.wr(ASFM_ADDR_CTRL, 8'h00);
		host.wr(ASFM_ADDR_TARGET, lvl);
		host.wr(ASFM_ADDR_CTRL, c);
	endtask

	task automatic t_regs();
		host.rd(ASFM_ADDR_CTRL, r8);
		check("ctrl reset", {8'h00, r8}, 16'h0000);
		host.rd(ASFM_ADDR_TARGET, r8);
		check("target reset", {8'h00, r8}, 16'h0000);
		check("flags reset", {13'h0, avail, watermark, overrun}, 16'h0000);
		host.wr(ASFM_ADDR_CTRL, 8'hff);
		host.wr(8'h2a, 8'h55);
		host.wr(ASFM_ADDR_TARGET, 8'hab);
		host.rd(ASFM_ADDR_CTRL, r8);
		check("ctrl mask", {8'h00, r8}, 16'h000f);
		host.rd(ASFM_ADDR_TARGET, r8);
		check("target rw", {8'h00, r8}, 16'h00ab);
		host.rd(8'h2a, r8);
		check("unmapped", {8'h00, r8}, 16'h0000);
	endtask

	// Temperature set: order, format, zeros past empty
	task automatic t_format();
		mode(8'h05, 8'h00);
		send(12'h123, 12'h800, 12'hfff, 12'h7ff);
		settle();
		host.rd_entry(e);
		check("x", e, ent(ASFM_TYPE_X, 12'h123));
		host.rd_entry(e);
		check("y", e, ent(ASFM_TYPE_Y, 12'h800));
		host.rd_entry(e);
		check("z", e, ent(ASFM_TYPE_Z, 12'hfff));
		host.rd_entry(e);
		check("temp", e, ent(ASFM_TYPE_T, 12'h7ff));
		check("avail cleared", {15'h0, avail}, 16'h0000);
		host.rd_entry(e);
		check("past empty", e, 16'h0000);
	endtask

	// Level with and without the high bit
	task automatic t_mark();
		mode(8'h0a, 8'h03);
		send(12'h001, 12'h002, 12'h003, 12'h000);
		settle();
		check("mark 259", {15'h0, watermark}, 16'h0000);
		check("avail", {15'h0, avail}, 16'h0001);
		host.wr(ASFM_ADDR_CTRL, 8'h02);
		@(posedge clk);
		#1;
		check("mark 3", {15'h0, watermark}, 16'h0001);
		host.rd_entry(e);
		check("mark cleared", {15'h0, watermark}, 16'h0000);
		host.wr(ASFM_ADDR_CTRL, 8'h00);
		@(posedge clk);
		#1;
		check("off empties", {15'h0, avail}, 16'h0000);
		send(12'h001, 12'h002, 12'h003, 12'h000);
		settle();
		check("off stores none", {15'h0, avail}, 16'h0000);
	endtask

	// Overfill keeping oldest; staging fills and refuses meanwhile
	task automatic t_oldest();
		mode(8'h01, 8'h00);
		burst(0, 199);
		settle();
		check("oldest loss", {15'h0, overrun}, 16'h0001);
		drain();
		check("oldest first", first, ent(ASFM_TYPE_X, 12'd0));
		check("holds 512", 16'(n >= ASFM_DEPTH), 16'h0001);
		check("overrun cleared", {15'h0, overrun}, 16'h0000);
	endtask

	// 600 entries streamed: the newest 512 remain
	task automatic t_stream();
		mode(8'h02, 8'h00);
		burst(0, 199);
		settle();
		check("stream loss", {15'h0, overrun}, 16'h0001);
		drain();
		check("stream count", 16'(n), 16'(ASFM_DEPTH));
		check("stream first", first, ent(ASFM_TYPE_Y, 12'd29));
		check("stream last", last, ent(ASFM_TYPE_Z, 12'd199));
	endtask

	// Six entries of history, then fill until full
	task automatic t_trig();
		mode(8'h03, 8'h06);
		burst(0, 4);
		settle();
		@(posedge clk);
		#1;
		activity = 1'b1;
		@(posedge clk);
		#1;
		activity = 1'b0;
		burst(5, 204);
		settle();
		drain();
		check("trig count", 16'(n), 16'(ASFM_DEPTH));
		check("trig first", first, ent(ASFM_TYPE_X, 12'd3));
		check("trig last", last, ent(ASFM_TYPE_Y, 12'd173));
	endtask

	initial begin
		rst = 1'b1;
		set_valid = 1'b0;
		activity = 1'b0;
		{x, y, z, t} = '0;
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_format();
		t_mark();
		t_oldest();
		t_stream();
		t_trig();
		complete_run();
	end
endmodule
`default_nettype wire
